// >>> core/flash_host_ctrl.sv
`timescale 1ns/1ns
module flash_host_ctrl
  import flash_host_pkg::*;
#(
  parameter int HALF_CYC = SCLK_HALF_CYC,
  parameter int GAP_CYC  = CS_HIGH_CYC,
  parameter int MAX_DATA = 256
) (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // user command port
  input  wire logic       cmdValid,
  output logic            cmdReady,
  input  wire logic [2:0] cmdOp,
  input  wire logic       cmdWide,
  input  wire logic [31:0] cmdAddr,
  input  wire logic [8:0] cmdLen,
  input  wire logic [7:0] cmdWrap,
  input  wire logic       addressSizeFlag,
  input  wire logic       quadLaneEnable,
  input  wire logic [7:0] wrData,
  input  wire logic       wrValid,
  output logic            wrReady,
  output logic            done,
  output logic            cmdErr,
  output logic            busy,
  output logic [7:0]      statusByte,
  output logic [7:0]      wrapSetting,
  // flash pins
  output logic            csN,
  output logic            sclk,
  output logic [3:0]      laneOut,
  output logic [3:0]      laneOe,
  input  wire logic [3:0] laneIn
);

  // the link clock is derived here; the sampling point needs settled
  // synchronised data, which four core cycles per half period provide
  if (HALF_CYC < 4) begin : g_half_chk
    $error("HALF_CYC below 4 breaks lane sampling");
  end
  if (GAP_CYC < 1) begin : g_gap_chk
    $error("GAP_CYC must be at least 1");
  end
  if (MAX_DATA < 1 || MAX_DATA > 256) begin : g_max_chk
    $error("MAX_DATA must be 1 to 256");
  end

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_LOAD  = 3'b001,
    S_WAIT  = 3'b010,
    S_SHIFT = 3'b011,
    S_END   = 3'b100,
    S_DONE  = 3'b101
  } state_e;

  typedef enum logic [1:0] {
    F_WRITE_ENABLE = 2'b00,
    F_MAIN         = 2'b01,
    F_POLL         = 2'b10
  } frame_e;

  typedef enum logic [2:0] {
    G_OP    = 3'b000,
    G_ADDR  = 3'b001,
    G_DUMMY = 3'b010,
    G_WRAP  = 3'b011,
    G_DATA  = 3'b100,
    G_STAT  = 3'b101
  } stage_e;

  localparam int GW = $clog2(GAP_CYC + 1);

  state_e      state;
  frame_e      frame;
  stage_e      stage;
  op_e         op;
  logic        wide;
  logic [31:0] addr;
  logic [8:0]  addrBytes;
  logic [8:0]  nData;
  logic [8:0]  cnt;
  logic [7:0]  shiftReg;
  logic [2:0]  clkLeft;
  logic        quadNow;
  logic [GW-1:0] gapCnt;
  logic [3:0]  laneSync;
  logic        tick;
  logic        isWrite;
  logic        isProg;
  logic        lastClk;
  logic [7:0]  opByte;
  logic [7:0]  addrByte;
  logic [7:0]  rxByte;

  flash_pin_sync #(
    .WIDTH (4)
  ) u_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .pinIn    (laneIn),
    .syncOut  (laneSync)
  );

  flash_clk_div #(
    .HALF_CYC (HALF_CYC)
  ) u_div (
    .core_clk (core_clk),
    .nrst     (nrst),
    .run      (state == S_SHIFT),
    .tick     (tick)
  );

  // command classes
  assign isProg  = (op == OP_PROG) || (op == OP_QPROG);
  assign isWrite = isProg || (op == OP_SECT) || (op == OP_HALF) ||
                   (op == OP_FULL);
  assign lastClk = (clkLeft == 3'd0);
  assign rxByte  = {shiftReg[6:0], laneSync[1]};
  assign addrByte = addr[8 * (addrBytes[2:0] - 3'd1 - cnt[2:0]) +: 8];

  // opcode for the current frame
  always_comb begin
    opByte = STATUS_READ_CMD;
    if (frame == F_WRITE_ENABLE) begin
      opByte = WRITE_ENABLE_CMD;
    end else if (frame == F_MAIN) begin
      case (op)
        OP_WRAP:  opByte = WRAP_SET_CMD;
        OP_PROG:  opByte = wide ? PAGE_WRITE_WIDE_ADDR_CMD
                                : PAGE_WRITE_CMD;
        OP_QPROG: opByte = wide ? FOUR_LANE_PAGE_WRITE_WIDE_CMD
                                : FOUR_LANE_PAGE_WRITE_CMD;
        OP_SECT:  opByte = wide ? SECTOR_CLEAR_WIDE_CMD
                                : SECTOR_CLEAR_CMD;
        OP_HALF:  opByte = wide ? HALF_BLOCK_CLEAR_WIDE_CMD
                                : HALF_BLOCK_CLEAR_CMD;
        OP_FULL:  opByte = wide ? FULL_BLOCK_CLEAR_WIDE_CMD
                                : FULL_BLOCK_CLEAR_CMD;
        default:  opByte = STATUS_READ_CMD;
      endcase
    end
  end

  // user handshake, latching of the command
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      op        <= OP_STATUS;
      wide      <= 1'b0;
      addr      <= '0;
      addrBytes <= ADDR_BYTES_NARROW;
      nData     <= '0;
      cmdReady  <= 1'b0;
      busy      <= 1'b0;
    end else if (state == S_IDLE && cmdValid && cmdReady) begin
      op        <= op_e'(cmdOp);
      wide      <= cmdWide;
      addr      <= cmdAddr;
      addrBytes <= (cmdWide || addressSizeFlag) ? ADDR_BYTES_WIDE
                                                : ADDR_BYTES_NARROW;
      // more bytes than a page would only wrap over the start of the page in the device
      nData     <= (cmdLen > 9'(MAX_DATA)) ? 9'(MAX_DATA) : cmdLen;
      cmdReady  <= 1'b0;
      busy      <= 1'b1;
    end else begin
      cmdReady  <= (state == S_IDLE) && !cmdReady ? 1'b1 :
                   (state == S_IDLE) && cmdReady;
      busy      <= (state != S_IDLE) && (state != S_DONE);
    end
  end

  // frame, stage and byte sequencing
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state      <= S_IDLE;
      frame      <= F_MAIN;
      stage      <= G_OP;
      cnt        <= '0;
      shiftReg   <= '0;
      clkLeft    <= '0;
      quadNow    <= 1'b0;
      gapCnt     <= '0;
      csN        <= 1'b1;
      sclk       <= 1'b0;
      laneOut    <= LANE_IDLE;
      laneOe     <= SINGLE_LANE_OE;
      wrReady    <= 1'b0;
      done       <= 1'b0;
      cmdErr     <= 1'b0;
      statusByte <= '0;
      wrapSetting <= WRAP_BYTE_RESET;
    end else begin
      done   <= 1'b0;
      cmdErr <= 1'b0;
      case (state)
        S_IDLE: begin
          if (cmdValid && cmdReady) begin
            // quad write is unavailable without quad enable
            if ((op_e'(cmdOp) == OP_QPROG && !quadLaneEnable) ||
                (cmdLen == 9'h000 &&
                 (op_e'(cmdOp) == OP_PROG ||
                  op_e'(cmdOp) == OP_QPROG))) begin
              cmdErr <= 1'b1;
              state  <= S_DONE;
            end else begin
              frame <= (op_e'(cmdOp) == OP_STATUS) ? F_POLL :
                       (op_e'(cmdOp) == OP_WRAP) ? F_MAIN :
                       F_WRITE_ENABLE;
              stage <= G_OP;
              cnt   <= '0;
              csN   <= 1'b0;
              state <= S_LOAD;
            end
          end
        end
        S_LOAD: begin
          quadNow <= 1'b0;
          laneOe  <= SINGLE_LANE_OE;
          clkLeft <= 3'd7;
          state   <= S_SHIFT;
          case (stage)
            G_OP: begin
              shiftReg <= opByte;
              laneOut  <= {LANE_IDLE[3:1], opByte[7]};
            end
            G_ADDR: begin
              shiftReg <= addrByte;
              laneOut  <= {LANE_IDLE[3:1], addrByte[7]};
            end
            G_WRAP: begin
              shiftReg <= wrapSetting;
              laneOut  <= {LANE_IDLE[3:1], wrapSetting[7]};
            end
            G_DATA: begin
              wrReady <= 1'b1;
              state   <= S_WAIT;
            end
            default: begin
              shiftReg <= 8'h00;
              laneOut  <= LANE_IDLE;
            end
          endcase
        end
        S_WAIT: begin
          // sclk parks low while the source stalls; select stays low
          if (wrValid && wrReady) begin
            wrReady  <= 1'b0;
            shiftReg <= wrData;
            state    <= S_SHIFT;
            if (op == OP_QPROG) begin
              quadNow <= 1'b1;
              clkLeft <= 3'd1;
              laneOe  <= QUAD_LANE_OE;
              laneOut <= wrData[7:4];
            end else begin
              clkLeft <= 3'd7;
              laneOut <= {LANE_IDLE[3:1], wrData[7]};
            end
          end
        end
        S_SHIFT: begin
          if (tick && !sclk) begin
            sclk <= 1'b1;
          end else if (tick) begin
            // sample late in the high half, where device data is settled
            sclk     <= 1'b0;
            shiftReg <= quadNow ? {shiftReg[3:0], 4'h0} : rxByte;
            clkLeft  <= clkLeft - 3'd1;
            if (quadNow) begin
              laneOut <= shiftReg[3:0];
            end else begin
              laneOut <= {LANE_IDLE[3:1], shiftReg[6]};
            end
            if (lastClk) begin
              // a byte just closed; only here may select rise
              state <= S_LOAD;
              cnt   <= cnt + 9'h001;
              case (stage)
                G_OP: begin
                  cnt <= '0;
                  if (frame == F_POLL) begin
                    stage <= G_STAT;
                  end else if (frame == F_WRITE_ENABLE) begin
                    state <= S_END;
                  end else if (op == OP_WRAP) begin
                    stage <= G_DUMMY;
                  end else begin
                    stage <= G_ADDR;
                  end
                end
                G_ADDR: begin
                  if (cnt == addrBytes - 9'h001) begin
                    cnt <= '0;
                    if (isProg) begin
                      stage <= G_DATA;
                    end else begin
                      state <= S_END;
                    end
                  end
                end
                G_DUMMY: begin
                  if (cnt == WRAP_DUMMY_BYTES - 9'h001) begin
                    stage <= G_WRAP;
                  end
                end
                G_DATA: begin
                  if (cnt == nData - 9'h001) begin
                    state <= S_END;
                  end
                end
                G_STAT: begin
                  statusByte <= rxByte;
                  state      <= S_END;
                end
                default: begin
                  state <= S_END;
                end
              endcase
            end
          end
        end
        S_END: begin
          csN     <= 1'b1;
          laneOut <= LANE_IDLE;
          laneOe  <= SINGLE_LANE_OE;
          if (gapCnt == GW'(GAP_CYC - 1)) begin
            gapCnt <= '0;
            stage  <= G_OP;
            cnt    <= '0;
            csN    <= 1'b0;
            state  <= S_LOAD;
            if (frame == F_WRITE_ENABLE) begin
              frame <= F_MAIN;
            end else if (frame == F_MAIN && isWrite) begin
              frame <= F_POLL;
            end else if (frame == F_POLL && isWrite &&
                         statusByte[BUSY_FLAG_POS]) begin
              frame <= F_POLL;
            end else begin
              csN   <= 1'b1;
              state <= S_DONE;
            end
          end else begin
            gapCnt <= gapCnt + GW'(1);
          end
        end
        S_DONE: begin
          done  <= 1'b1;
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
      // the wrap byte is taken when the command is accepted
      if (state == S_IDLE && cmdValid && cmdReady &&
          op_e'(cmdOp) == OP_WRAP) begin
        wrapSetting <= cmdWrap;
      end
    end
  end

endmodule : flash_host_ctrl

// >>> core/flash_host_pkg.sv
package flash_host_pkg;

  // core clock and link timing
  localparam int CORE_PERIOD_NS  = 10;
  localparam int SCLK_HALF_NS    = 40;
  localparam int CS_HIGH_NS      = 50;
  localparam int SCLK_HALF_CYC   =
    (SCLK_HALF_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int CS_HIGH_CYC     =
    (CS_HIGH_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;

  // opcodes of the device
  localparam logic [7:0] WRITE_ENABLE_CMD              = 8'h06;
  localparam logic [7:0] STATUS_READ_CMD               = 8'h05;
  localparam logic [7:0] WRAP_SET_CMD                  = 8'h77;
  localparam logic [7:0] PAGE_WRITE_CMD                = 8'h02;
  localparam logic [7:0] PAGE_WRITE_WIDE_ADDR_CMD      = 8'h12;
  localparam logic [7:0] FOUR_LANE_PAGE_WRITE_CMD      = 8'h32;
  localparam logic [7:0] FOUR_LANE_PAGE_WRITE_WIDE_CMD = 8'h3E;
  localparam logic [7:0] SECTOR_CLEAR_CMD              = 8'h20;
  localparam logic [7:0] SECTOR_CLEAR_WIDE_CMD         = 8'h21;
  localparam logic [7:0] HALF_BLOCK_CLEAR_CMD          = 8'h52;
  localparam logic [7:0] HALF_BLOCK_CLEAR_WIDE_CMD     = 8'h5C;
  localparam logic [7:0] FULL_BLOCK_CLEAR_CMD          = 8'hD8;
  localparam logic [7:0] FULL_BLOCK_CLEAR_WIDE_CMD     = 8'hDC;

  // frame layout
  localparam logic [8:0] WRAP_DUMMY_BYTES = 9'h003;
  localparam logic [8:0] PAGE_BYTES       = 9'h100;
  localparam logic [8:0] ADDR_BYTES_NARROW = 9'h003;
  localparam logic [8:0] ADDR_BYTES_WIDE   = 9'h004;

  // status byte fields
  localparam int BUSY_FLAG_POS  = 0;
  localparam int WRITE_LATCH_POS = 1;

  // wrap byte fields and reset value
  localparam int         WRAP_DISABLE_POS = 4;
  localparam int         WRAP_LENGTH_POS  = 5;
  localparam logic [7:0] WRAP_BYTE_RESET  = 8'h10;

  // lane drive in single-lane mode: hold and protect high, lane1 input
  localparam logic [3:0] SINGLE_LANE_OE  = 4'hD;
  localparam logic [3:0] QUAD_LANE_OE    = 4'hF;
  localparam logic [3:0] LANE_IDLE       = 4'hC;

  typedef enum logic [2:0] {
    OP_WRAP   = 3'b000,
    OP_PROG   = 3'b001,
    OP_QPROG  = 3'b010,
    OP_SECT   = 3'b011,
    OP_HALF   = 3'b100,
    OP_FULL   = 3'b101,
    OP_STATUS = 3'b110
  } op_e;

endpackage : flash_host_pkg

// >>> core/flash_pin_sync.sv
`timescale 1ns/1ns
module flash_pin_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1;

  // two flops; only the second stage is seen by the logic
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stage1  <= '0;
      syncOut <= '0;
    end else begin
      stage1  <= pinIn;
      syncOut <= stage1;
    end
  end

endmodule : flash_pin_sync

// >>> core/flash_clk_div.sv
`timescale 1ns/1ns
module flash_clk_div #(
  parameter int HALF_CYC = 4
) (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic run,
  output logic      tick
);

  localparam int CW = $clog2(HALF_CYC + 1);

  logic [CW-1:0] count;

  // restarts whenever run drops so each bit gets a full half period
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (!run) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (count == CW'(HALF_CYC - 2)) begin
      count <= count + CW'(1);
      tick  <= 1'b1;
    end else if (count == CW'(HALF_CYC - 1)) begin
      count <= '0;
      tick  <= 1'b0;
    end else begin
      count <= count + CW'(1);
      tick  <= 1'b0;
    end
  end

endmodule : flash_clk_div

// >>> testbench/flash_dev_model.sv
`timescale 1ns/1ns
module flash_dev_model #(
  parameter int BUSY_POLLS = 2
) (
  input  wire logic        csN,
  input  wire logic        sclk,
  input  wire logic [3:0]  laneIn,
  input  wire logic        addressSizeFlag,
  input  wire logic        quadLaneEnable,
  input  wire logic        locked,
  output logic             so,
  output logic [7:0]       lastOp,
  output logic [31:0]      lastAddr,
  output logic [8:0]       nData,
  output logic [7:0]       lastData,
  output logic [7:0]       wrapReg,
  output logic [7:0]       endLoc,
  output logic [6:0]       wrapSpan
);
  logic [7:0]  sh, op, dat, outSh;
  logic [31:0] adr;
  logic [8:0]  cnt;
  logic        write_enable_latch, write_in_progress_flag, quad, ok;
  int          bits, nb, aBytes, polls;

  // power-up: wrapping off, latch clear
  initial begin
    {so, write_enable_latch, write_in_progress_flag, lastOp, lastAddr, nData, lastData, endLoc, wrapSpan} = '0;
    wrapReg = 8'h10;
  end

  // each frame starts from a clean shifter
  always @(negedge csN) begin
    {bits, nb, cnt, adr, op} = '0;
  end

  // bits taken on sclk rise, four at a time in quad data
  always @(posedge sclk) if (!csN) begin
    quad = op inside {8'h32, 8'h3E} && nb > aBytes;
    sh = quad ? {sh[3:0], laneIn} : {sh[6:0], laneIn[0]};
    bits += quad ? 4 : 1;
    if (bits % 8 == 0) begin
      if (nb == 0) begin
        op = sh;
        aBytes = (sh inside {8'h12, 8'h3E, 8'h21, 8'h5C, 8'hDC} ||
                  addressSizeFlag) && sh != 8'h77 ? 4 : 3;
        outSh = {6'h00, write_enable_latch, write_in_progress_flag};
      end else if (nb <= aBytes) adr = {adr[23:0], sh};
      else begin
        cnt++;
        dat = sh;
      end
      nb++;
    end
  end

  // status leaves on sclk fall, msb first
  always @(negedge sclk) if (!csN && op == 8'h05) begin
    so = outSh[7];
    outSh = {outSh[6:0], outSh[7]};
  end

  // select rising ends the frame; partial bytes void it
  always @(posedge csN) begin
    so = ~so; // a released line must not keep its level
    ok = bits > 0 && bits % 8 == 0 && !write_in_progress_flag;
    if (op inside {8'h02, 8'h12, 8'h32, 8'h3E})
      ok = ok && cnt > 0 && (quadLaneEnable || !(op inside {8'h32, 8'h3E}));
    else if (op inside {8'h20, 8'h21, 8'h52, 8'h5C, 8'hD8, 8'hDC})
      ok = ok && nb == aBytes + 1;
    else ok = 1'b0;
    if (op == 8'h05 && write_in_progress_flag && ++polls >= BUSY_POLLS)
      {write_in_progress_flag, write_enable_latch} = 2'b00;
    if (op == 8'h06 && bits == 8) begin
      write_enable_latch = 1'b1;
      {lastOp, lastAddr, nData} = {op, 41'h0};
    end
    if (op == 8'h77 && bits == 40) begin
      wrapReg = dat;
      // section size that later quad reads would wrap inside
      wrapSpan = dat[4] ? 7'h00 : 7'h08 << dat[6:5];
      {lastOp, lastAddr, nData} = {op, 24'h0, dat, 9'h000};
    end
    if (ok && write_enable_latch && !locked) begin
      write_in_progress_flag = 1'b1;
      polls = 0;
      // last byte lands inside the same page, wrapping past its end
      endLoc = adr[7:0] + cnt[7:0] - 8'h01;
      {lastOp, lastAddr, nData, lastData} = {op, adr, cnt, dat};
    end
  end
endmodule : flash_dev_model

// >>> testbench/flash_host_ctrl_sva.sv
`timescale 1ns/1ns
module flash_host_ctrl_sva
  import flash_host_pkg::*;
#(
  parameter int HALF_CYC = SCLK_HALF_CYC
) (
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic       cmdValid,
  input wire logic       cmdReady,
  input wire logic [2:0] cmdOp,
  input wire logic [8:0] cmdLen,
  input wire logic       quadLaneEnable,
  input wire logic       done,
  input wire logic       cmdErr,
  input wire logic       busy,
  input wire logic       csN,
  input wire logic       sclk,
  input wire logic [3:0] laneOe,
  input wire logic [7:0] wrapSetting
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  wire take = cmdValid && cmdReady;
  int  hiCnt;

  // length of the running sclk high phase
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst) hiCnt <= 0;
    else hiCnt <= sclk ? hiCnt + 1 : 0;

  err_done_a: assert property (cmdErr |=> done)
    else $error("refusal without done");
  quad_refuse_a: assert property (
    take && cmdOp == 3'd2 && !quadLaneEnable |=> cmdErr && csN)
    else $error("quad write not refused");
  empty_refuse_a: assert property (
    take && cmdOp inside {3'd1, 3'd2} && cmdLen == 9'h000
      |=> cmdErr ##1 done && csN) else $error("empty write not refused");
  idle_pins_a: assert property (cmdReady |-> csN && !sclk)
    else $error("pins moved while idle");
  frame_start_a: assert property (
    take && !(cmdOp inside {3'd1, 3'd2}) |=> busy && !csN)
    else $error("frame did not start");
  clk_framed_a: assert property (sclk |-> !csN)
    else $error("sclk outside frame");
  sclk_half_a: assert property ($fell(sclk) |-> hiCnt == HALF_CYC)
    else $error("sclk high phase wrong");
  cs_rise_a: assert property ($rose(csN) |-> !sclk && !$past(sclk))
    else $error("select rose mid bit");
  quad_lanes_a: assert property (
    laneOe == QUAD_LANE_OE |-> quadLaneEnable && !csN)
    else $error("quad drive without enable");
  done_ready_a: assert property (done |=> cmdReady)
    else $error("not ready after done");
  wrap_quiet_a: assert property (
    !$stable(wrapSetting) |-> $past(busy) || $past(take))
    else $error("wrap setting changed when idle");
endmodule : flash_host_ctrl_sva

// >>> testbench/tb.sv
`timescale 1ns/1ns
`define CHK(a, b) begin totalChecks++; if ((a) !== (b)) begin errCount++; \
  $display("ERROR %0t: got %h want %h", $time, a, b); end end
module tb
  import flash_host_pkg::*;
;
  typedef struct packed {
    logic        err;
    logic [7:0]  op;
    logic [31:0] addr;
    logic [8:0]  n;
    logic [1:0]  sts;
  } exp_s;
  localparam logic [7:0] OPC [2][6] = '{
    '{8'h00, 8'h02, 8'h32, 8'h20, 8'h52, 8'hD8},
    '{8'h00, 8'h12, 8'h3E, 8'h21, 8'h5C, 8'hDC}};
  logic        core_clk = 1'b0, nrst = 1'b0, cmdValid = 1'b0, cmdWide = 1'b0;
  logic        addressSizeFlag = 1'b0, quadLaneEnable = 1'b1, locked = 1'b0;
  logic        wrValid = 1'b1, errSeen = 1'b0;
  logic        cmdReady, wrReady, done, cmdErr, busy, csN, sclk, so;
  logic [2:0]  cmdOp = 3'h0;
  logic [31:0] cmdAddr = 32'h0, seed = 32'h0000B9F4, a, lastAddr;
  logic [8:0]  cmdLen = 9'h000, len, nData;
  logic [7:0]  cmdWrap = 8'h10, wrData = 8'h00, lastSent, wb, lastData;
  logic [7:0]  statusByte, wrapSetting, lastOp, wrapReg;
  logic [3:0]  laneIn, laneOut, laneOe;
  logic [7:0]  endLoc;
  logic [6:0]  wrapSpan;
  int          errCount = 0, totalChecks = 0, i, j;
  exp_s        e, prev, expQ[$];

  always #5 core_clk = ~core_clk;

  flash_host_ctrl i_dut (.core_clk, .nrst, .cmdValid, .cmdReady, .cmdOp,
    .cmdWide, .cmdAddr, .cmdLen, .cmdWrap, .addressSizeFlag, .quadLaneEnable,
    .wrData, .wrValid, .wrReady, .done, .cmdErr, .busy, .statusByte,
    .wrapSetting, .csN, .sclk, .laneOut, .laneOe, .laneIn);
  flash_dev_model i_dev (.csN, .sclk, .laneIn, .addressSizeFlag,
    .quadLaneEnable, .locked, .so, .lastOp, .lastAddr, .nData, .lastData,
    .wrapReg, .endLoc, .wrapSpan);

  // hold and protect lines pulled up; lane1 is the device output
  assign laneIn = {laneOe[3] ? laneOut[3] : 1'b1, laneOe[2] ? laneOut[2] : 1'b1,
                   laneOe[1] ? laneOut[1] : so, laneOe[0] ? laneOut[0] : 1'b1};

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // fresh data byte after every accepted one
  always @(posedge core_clk) if (wrValid && wrReady) begin
    lastSent = wrData;
    wrData <= 8'(rnd());
  end

  // results checked against the oldest note when a command ends
  always @(negedge core_clk) begin
    if (cmdErr === 1'b1) errSeen = 1'b1;
    if (done === 1'b1) begin
      `CHK(expQ.size() > 0, 1'b1)
      e = expQ.pop_front();
      `CHK(errSeen, e.err)
      if (!e.err) begin
        `CHK(lastOp, e.op)
        `CHK(lastAddr, e.addr)
        `CHK(nData, e.n)
        `CHK(statusByte[1:0], e.sts)
        if (e.n != 0) `CHK(lastData, lastSent)
        if (e.n != 0) `CHK(endLoc, 8'(e.addr[7:0] + e.n - 9'h001))
        if (e.op == 8'h77) `CHK(wrapSpan, 7'(e.addr[4] ? 0 : 8 << e.addr[6:5]))
        if (e.op == 8'h77) `CHK(wrapSetting, e.addr[7:0])
        if (e.op == 8'h77) `CHK(wrapReg, e.addr[7:0])
      end
      errSeen = 1'b0;
    end
  end

  task finalReport();
    $display("checks %0d errors %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finalReport

  // bounded wait on ready (0) or done (1)
  task automatic waitHigh(input bit sel);
    int k = 0;
    do @(negedge core_clk); while ((sel ? done : cmdReady) !== 1'b1 && ++k < 30000);
    if (k == 30000) begin
      errCount++;
      $display("ERROR %0t: wait ran out", $time);
      finalReport();
    end
  endtask : waitHigh

  task automatic run(input logic [2:0] op, input logic w, input logic [8:0] n,
                     input exp_s ex);
    cmdValid <= 1'b1;
    cmdOp <= op;
    cmdWide <= w;
    cmdAddr <= a;
    cmdLen <= n;
    cmdWrap <= wb;
    expQ.push_back(ex);
    if (!ex.err) prev = ex;
    waitHigh(0);
    @(posedge core_clk);
    cmdValid <= 1'b0;
    waitHigh(1);
    @(posedge core_clk);
  endtask : run

  initial begin
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    {a, wb} = '0;
    run(3'd6, 1'b0, 9'h000, '{1'b0, 8'h00, 32'h0, 9'h000, 2'b00});
    // all wrap lengths, then wrapping off again
    for (i = 0; i < 5; i++) begin
      wb = (i < 4) ? 8'(i << 5) : 8'h10;
      run(3'd0, 1'b0, 9'h000, '{1'b0, 8'h77, {24'h0, wb}, 9'h000, 2'b00});
    end
    // every write and clear opcode, narrow and wide
    for (i = 1; i < 6; i++) begin
      for (j = 0; j < 2; j++) begin
        a = rnd();
        len = (i < 3) ? 9'(1 + rnd() % 4) : 9'h000;
        run(3'(i), j[0], len, '{1'b0, OPC[j][i],
            j ? a : {8'h00, a[23:0]}, len, 2'b00});
      end
    end
    addressSizeFlag <= 1'b1;
    a = rnd();
    run(3'd3, 1'b0, 9'h000, '{1'b0, 8'h20, a, 9'h000, 2'b00});
    addressSizeFlag <= 1'b0;
    run(3'd1, 1'b0, 9'h12C, '{1'b0, 8'h02, {8'h00, a[23:0]}, 9'h100,
        2'b00});
    quadLaneEnable <= 1'b0;
    run(3'd2, 1'b0, 9'h004, '{1'b1, 8'h00, 32'h0, 9'h000, 2'b00});
    quadLaneEnable <= 1'b1;
    run(3'd1, 1'b0, 9'h000, '{1'b1, 8'h00, 32'h0, 9'h000, 2'b00});
    run(3'd6, 1'b0, 9'h000, prev);
    locked <= 1'b1;
    run(3'd1, 1'b0, 9'h003, '{1'b0, 8'h06, 32'h0, 9'h000, 2'b10});
    locked <= 1'b0;
    a = rnd();
    run(3'd5, 1'b1, 9'h000, '{1'b0, 8'hDC, a, 9'h000, 2'b00});
    finalReport();
  end
endmodule : tb

bind flash_host_ctrl flash_host_ctrl_sva #(.HALF_CYC(HALF_CYC)) i_chk (
  .core_clk, .nrst, .cmdValid, .cmdReady, .cmdOp, .cmdLen, .quadLaneEnable,
  .done, .cmdErr, .busy, .csN, .sclk, .laneOe, .wrapSetting);
